// [design/pmmp_dual_access_ram_block.sv]
`timescale 1ns/1ps
module pmmp_dual_access_ram_block #(
    parameter int WORDS = 8192,
    parameter int AW = 13,
    parameter int DW = 16
) (
    // clock and reset
    input logic clk_sys,
    input logic rst,
    // program-side port
    input logic [AW-1:0] aAddr,
    input logic aWe,
    input logic [DW-1:0] aWdata,
    output logic [DW-1:0] aRdata,
    // data-side port
    input logic [AW-1:0] bAddr,
    input logic bWe,
    input logic [DW-1:0] bWdata,
    output logic [DW-1:0] bRdata
);

    logic [DW-1:0] mem [WORDS];

    // two reads, or one read and one write, per cycle
    // a double write keeps the data side and drops the program side
    always_ff @(posedge clk_sys) begin
        if (bWe) begin
            mem[bAddr] <= bWdata;
        end else if (aWe) begin
            mem[aAddr] <= aWdata;
        end
    end

    // reads are combinational so the owner can register them once
    assign aRdata = mem[aAddr];
    assign bRdata = mem[bAddr];

    property p_bWrite;
        @(posedge clk_sys) disable iff (rst)
        bWe ##1 bAddr == $past(bAddr) |-> bRdata == $past(bWdata);
    endproperty
    a_bWrite: assert property (p_bWrite)
        else $error("data-side write not read back");

    property p_aWrite;
        @(posedge clk_sys) disable iff (rst)
        aWe && !bWe ##1 aAddr == $past(aAddr) |-> aRdata == $past(aWdata);
    endproperty
    a_aWrite: assert property (p_aWrite)
        else $error("program-side write not read back");

endmodule

// [design/pmmp_map.sv]
`timescale 1ns/1ps
module pmmp_map #(
    parameter logic [15:0] BOOT_BRANCH_WORD = 16'hF073,
    parameter logic [15:0] ROM_FILL_WORD = 16'h0000
) (
    // clock and reset
    input logic clk_sys,
    input logic rst,
    // mode strap
    input logic microModeSelectPin,
    // core program and data buses
    input pmmp_pkg::pmmp_req_s progReq,
    input pmmp_pkg::pmmp_xfer_s xferReq,
    input pmmp_pkg::pmmp_req_s dataReq,
    output pmmp_pkg::pmmp_rsp_s progRsp,
    output pmmp_pkg::pmmp_rsp_s dataRsp,
    // flow-control events
    input pmmp_pkg::pmmp_far_s farOp,
    input logic delaySlotsDone,
    input pmmp_pkg::pmmp_vec_s vecTake,
    output logic pcLoadValid,
    output logic [pmmp_pkg::FULL_W-1:0] pcLoadAddr,
    output logic [pmmp_pkg::PAGE_W-1:0] programPage,
    // external memory bus
    output pmmp_pkg::pmmp_ext_s extReq,
    input pmmp_pkg::pmmp_rsp_s extRsp
);

    localparam int AW = pmmp_pkg::ADDR_W;
    localparam int PW = pmmp_pkg::PAGE_W;
    localparam int FW = pmmp_pkg::FULL_W;
    localparam int DW = pmmp_pkg::DATA_W;
    localparam int RW = pmmp_pkg::RAM_IDX_W;
    localparam int NB = pmmp_pkg::RAM_BLOCKS;

    pmmp_pkg::pmmp_boot_e state_q, state_d;
    logic mpmc_q, ram_overlay_bit_q;
    logic [pmmp_pkg::VECTOR_PAGE_POINTER_W-1:0] vector_page_pointer_q;
    logic [PW-1:0] xpc_q;
    logic farPend_q;
    logic [FW-1:0] farTarget_q;
    logic extRdProg_q;
    logic pcLoadValid_q;
    logic [FW-1:0] pcLoadAddr_q;
    pmmp_pkg::pmmp_rsp_s progRsp_q, dataRsp_q;
    pmmp_pkg::pmmp_ext_s ext_q;

    logic running, pAct, pWr, pInRam, pInRom, pExt, pBlk;
    logic [FW-1:0] pFull;
    logic [AW-1:0] pLow;
    logic [PW-1:0] pPage;
    logic [DW-1:0] pWdata;
    logic dAct, dInRam, dXpc, dPmst, dExt, dBlk, dXpcWr, dPmstWr;
    logic farNow, farLate, farDefer;
    logic [DW-1:0] ramARd [NB];
    logic [DW-1:0] ramBRd [NB];

    // mask contents are fixed at manufacture; only the reset branch
    // into the boot image is modelled, tables read as fill
    function automatic logic [15:0] romWord(input logic [15:0] a);
        if (a == pmmp_pkg::VEC_BASE) begin
            romWord = BOOT_BRANCH_WORD;
        end else if (a == pmmp_pkg::VEC_BRANCH_TGT) begin
            romWord = pmmp_pkg::BOOT_BASE;
        end else begin
            romWord = ROM_FILL_WORD;
        end
    endfunction

    always_comb begin
        running = state_q == pmmp_pkg::ST_RUN;
        if (xferReq.valid) begin
            pAct = running;
            pWr = xferReq.write;
            pFull = xferReq.accum;
            pWdata = xferReq.wdata;
        end else begin
            pAct = running && progReq.valid;
            pWr = progReq.write;
            pFull = {xpc_q, progReq.addr};
            pWdata = progReq.wdata;
        end
        pLow = pFull[AW-1:0];
        pPage = pFull[FW-1:AW];
        pBlk = pLow[RW];
        // overlay places ram at 0060h-3FFFh of every page
        pInRam = ram_overlay_bit_q && pLow >= pmmp_pkg::RAM_LO
            && pLow <= pmmp_pkg::RAM_HI;
        pInRom = !mpmc_q && pPage == pmmp_pkg::ROM_PAGE
            && pLow >= pmmp_pkg::ROM_BASE;
        pExt = pAct && !pInRam && !pInRom;
    end

    always_comb begin
        dAct = running && dataReq.valid;
        dBlk = dataReq.addr[RW];
        dInRam = dataReq.addr >= pmmp_pkg::RAM_LO
            && dataReq.addr <= pmmp_pkg::RAM_HI;
        dXpc = dataReq.addr == pmmp_pkg::XPC_ADDR;
        dPmst = dataReq.addr == pmmp_pkg::PROCESSOR_MODE_STATUS_ADDR;
        dExt = dAct && !dInRam && !dXpc && !dPmst;
        dXpcWr = dAct && dXpc && dataReq.write;
        dPmstWr = dAct && dPmst && dataReq.write;
        farNow = running && farOp.op != pmmp_pkg::FAR_NONE
            && !farOp.delayed;
        farDefer = running && farOp.op != pmmp_pkg::FAR_NONE
            && farOp.delayed;
        farLate = farPend_q && delaySlotsDone;
    end

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_ram
            pmmp_dual_access_ram_block #(
                .WORDS(pmmp_pkg::RAM_BLOCK_WORDS),
                .AW(RW),
                .DW(DW)
            ) u_blk (
                .clk_sys(clk_sys),
                .rst(rst),
                .aAddr(pLow[RW-1:0]),
                .aWe(pAct && pInRam && pWr && pBlk == 1'(g)),
                .aWdata(pWdata),
                .aRdata(ramARd[g]),
                .bAddr(dataReq.addr[RW-1:0]),
                .bWe(dAct && dInRam && dataReq.write && dBlk == 1'(g)),
                .bWdata(dataReq.wdata),
                .bRdata(ramBRd[g])
            );
        end
    endgenerate

    // boot sequence: strap sample, reset vector, run
    always_comb begin
        case (state_q)
            pmmp_pkg::ST_RESET: state_d = pmmp_pkg::ST_STRAP;
            pmmp_pkg::ST_STRAP: state_d = pmmp_pkg::ST_VEC;
            pmmp_pkg::ST_VEC: state_d = pmmp_pkg::ST_RUN;
            pmmp_pkg::ST_RUN: state_d = pmmp_pkg::ST_RUN;
            default: state_d = pmmp_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= pmmp_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // strap caught after release; async reset may only load a constant
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mpmc_q <= 1'b0;
        end else if (state_q == pmmp_pkg::ST_STRAP) begin
            mpmc_q <= microModeSelectPin;
        end else if (dPmstWr) begin
            mpmc_q <= dataReq.wdata[pmmp_pkg::MPMC_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vector_page_pointer_q <= pmmp_pkg::VECTOR_PAGE_POINTER_RESET;
            ram_overlay_bit_q <= 1'b0;
        end else if (dPmstWr) begin
            vector_page_pointer_q <= dataReq.wdata[pmmp_pkg::VECTOR_PAGE_POINTER_LSB +: pmmp_pkg::VECTOR_PAGE_POINTER_W];
            ram_overlay_bit_q <= dataReq.wdata[pmmp_pkg::RAM_OVERLAY_BIT_BIT];
        end
    end

    // far ops beat a same-cycle register write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xpc_q <= pmmp_pkg::XPC_RESET;
        end else if (farNow) begin
            xpc_q <= farOp.target[FW-1:AW];
        end else if (farLate) begin
            xpc_q <= farTarget_q[FW-1:AW];
        end else if (dXpcWr) begin
            xpc_q <= dataReq.wdata[PW-1:0];
        end
    end

    // delayed forms wait for the core to finish the delay slots
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            farPend_q <= 1'b0;
            farTarget_q <= '0;
        end else if (farDefer) begin
            farPend_q <= 1'b1;
            farTarget_q <= farOp.target;
        end else if (farLate) begin
            farPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pcLoadValid_q <= 1'b0;
            pcLoadAddr_q <= '0;
        end else begin
            pcLoadValid_q <= 1'b0;
            if (state_q == pmmp_pkg::ST_VEC) begin
                pcLoadValid_q <= 1'b1;
                pcLoadAddr_q <= {pmmp_pkg::XPC_RESET, vector_page_pointer_q,
                    pmmp_pkg::RESET_VEC_NUM, pmmp_pkg::SLOT_OFS};
            end else if (farNow) begin
                pcLoadValid_q <= 1'b1;
                pcLoadAddr_q <= farOp.target;
            end else if (farLate) begin
                pcLoadValid_q <= 1'b1;
                pcLoadAddr_q <= farTarget_q;
            end else if (running && vecTake.valid) begin
                pcLoadValid_q <= 1'b1;
                pcLoadAddr_q <= {xpc_q, vector_page_pointer_q, vecTake.num,
                    pmmp_pkg::SLOT_OFS};
            end
        end
    end

    // one external transfer per cycle; program side wins, a same-cycle data access is dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_q <= '0;
            extRdProg_q <= 1'b0;
        end else begin
            ext_q.valid <= pExt || dExt;
            ext_q.prog <= pExt;
            if (pExt) begin
                ext_q.write <= pWr;
                ext_q.addr <= pFull;
                ext_q.wdata <= pWdata;
                extRdProg_q <= !pWr;
            end else if (dExt) begin
                ext_q.write <= dataReq.write;
                ext_q.addr <= {pmmp_pkg::DATA_PAGE, dataReq.addr};
                ext_q.wdata <= dataReq.wdata;
                extRdProg_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            progRsp_q <= '0;
        end else begin
            progRsp_q.valid <= (pAct && !pExt && !pWr)
                || (extRsp.valid && extRdProg_q);
            if (extRsp.valid && extRdProg_q) begin
                progRsp_q.rdata <= extRsp.rdata;
            end else if (pInRam) begin
                progRsp_q.rdata <= ramARd[pBlk];
            end else begin
                progRsp_q.rdata <= romWord(pLow);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dataRsp_q <= '0;
        end else begin
            dataRsp_q.valid <= (dAct && !dExt && !dataReq.write)
                || (extRsp.valid && !extRdProg_q);
            if (extRsp.valid && !extRdProg_q) begin
                dataRsp_q.rdata <= extRsp.rdata;
            end else if (dInRam) begin
                dataRsp_q.rdata <= ramBRd[dBlk];
            end else if (dXpc) begin
                dataRsp_q.rdata <= {{(DW-PW){1'b0}}, xpc_q};
            end else begin
                dataRsp_q.rdata <= {vector_page_pointer_q, mpmc_q, ram_overlay_bit_q,
                    pmmp_pkg::PROCESSOR_MODE_STATUS_LOW_ZERO};
            end
        end
    end

    assign progRsp = progRsp_q;
    assign dataRsp = dataRsp_q;
    assign pcLoadValid = pcLoadValid_q;
    assign pcLoadAddr = pcLoadAddr_q;
    assign programPage = xpc_q;
    assign extReq = ext_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_bootStart;
        state_q == pmmp_pkg::ST_STRAP ##1 state_q == pmmp_pkg::ST_VEC;
    endsequence
    property p_bootVector;
        s_bootStart |=> pcLoadValid_q
            && pcLoadAddr_q == {pmmp_pkg::XPC_RESET, pmmp_pkg::VEC_BASE};
    endproperty
    a_bootVector: assert property (p_bootVector)
        else $error("reset vector not taken at FF80h");

    property p_resetState;
        state_q == pmmp_pkg::ST_STRAP |-> xpc_q == pmmp_pkg::XPC_RESET
            && vector_page_pointer_q == pmmp_pkg::VECTOR_PAGE_POINTER_RESET;
    endproperty
    a_resetState: assert property (p_resetState)
        else $error("page or vector pointer wrong after reset");

    property p_vecSlot;
        running && vecTake.valid && !farNow && !farLate |=> pcLoadValid_q
            && pcLoadAddr_q == {$past(xpc_q), $past(vector_page_pointer_q),
            $past(vecTake.num), pmmp_pkg::SLOT_OFS};
    endproperty
    a_vecSlot: assert property (p_vecSlot)
        else $error("vector slot address wrong");

    property p_farNow;
        farNow |=> pcLoadValid_q && pcLoadAddr_q == $past(farOp.target)
            && xpc_q == pcLoadAddr_q[FW-1:AW];
    endproperty
    a_farNow: assert property (p_farNow)
        else $error("far op did not load page and target");

    sequence s_farDeferred;
        farDefer && !dXpcWr ##1 farPend_q;
    endsequence
    property p_farDefer;
        farDefer && !dXpcWr |-> s_farDeferred
            ##0 xpc_q == $past(xpc_q) && !pcLoadValid_q;
    endproperty
    a_farDefer: assert property (p_farDefer)
        else $error("delayed far op acted early");

    property p_xpcHold;
        !farNow && !farLate && !dXpcWr |=> $stable(xpc_q);
    endproperty
    a_xpcHold: assert property (p_xpcHold)
        else $error("page changed without a far op or write");

    property p_xpcRead;
        dAct && dXpc && !dataReq.write |=> dataRsp_q.valid
            && dataRsp_q.rdata == {{(DW-PW){1'b0}}, $past(xpc_q)};
    endproperty
    a_xpcRead: assert property (p_xpcRead)
        else $error("page register read back wrong");

    property p_xferExt;
        xferReq.valid && pExt |=> ext_q.valid && ext_q.prog
            && ext_q.addr == $past(xferReq.accum);
    endproperty
    a_xferExt: assert property (p_xferExt)
        else $error("transfer op address not 20-bit accumulator");

    property p_overlayOff;
        pAct && !ram_overlay_bit_q && pPage != pmmp_pkg::ROM_PAGE
            && pLow <= pmmp_pkg::RAM_HI |=> ext_q.valid && ext_q.prog;
    endproperty
    a_overlayOff: assert property (p_overlayOff)
        else $error("low page area not sent external");

    property p_romHit;
        pAct && pInRom && !pWr |=> progRsp_q.valid && !ext_q.prog;
    endproperty
    a_romHit: assert property (p_romHit)
        else $error("rom read not answered on chip");

endmodule

// [inc/pmmp_pkg.sv]
package pmmp_pkg;

    // widths
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 4;
    localparam int FULL_W = 20;
    localparam int DATA_W = 16;
    localparam int VEC_NUM_W = 5;

    // on-chip rom layout
    localparam logic [15:0] ROM_BASE = 16'hF000;
    localparam logic [15:0] BOOT_BASE = 16'hF800;
    localparam logic [15:0] MULAW_BASE = 16'hFC00;
    localparam logic [15:0] ALAW_BASE = 16'hFD00;
    localparam logic [15:0] SINE_BASE = 16'hFE00;
    localparam logic [15:0] TEST_BASE = 16'hFF00;
    localparam logic [15:0] VEC_BASE = 16'hFF80;
    localparam logic [15:0] VEC_BRANCH_TGT = 16'hFF81;
    localparam int ROM_WORDS = 4096;

    // dual-access ram
    localparam logic [15:0] RAM_LO = 16'h0060;
    localparam logic [15:0] RAM_HI = 16'h3FFF;
    localparam int RAM_BLOCKS = 2;
    localparam int RAM_BLOCK_WORDS = 8192;
    localparam int RAM_IDX_W = 13;

    // memory-mapped registers in data space
    localparam logic [15:0] XPC_ADDR = 16'h001E;
    localparam logic [15:0] PROCESSOR_MODE_STATUS_ADDR = 16'h001D;

    // mode status fields
    localparam int VECTOR_PAGE_POINTER_LSB = 7;
    localparam int VECTOR_PAGE_POINTER_W = 9;
    localparam int MPMC_BIT = 6;
    localparam int RAM_OVERLAY_BIT_BIT = 5;
    localparam logic [4:0] PROCESSOR_MODE_STATUS_LOW_ZERO = 5'h00;

    // reset values and fixed pages
    localparam logic [8:0] VECTOR_PAGE_POINTER_RESET = 9'h1FF;
    localparam logic [3:0] XPC_RESET = 4'h0;
    localparam logic [3:0] ROM_PAGE = 4'h0;
    localparam logic [3:0] DATA_PAGE = 4'h0;
    localparam logic [4:0] RESET_VEC_NUM = 5'h00;
    localparam logic [1:0] SLOT_OFS = 2'h0;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_STRAP = 2'b01,
        ST_VEC = 2'b11,
        ST_RUN = 2'b10
    } pmmp_boot_e;

    typedef enum logic [2:0] {
        FAR_NONE = 3'h0,
        FAR_B = 3'h1,
        FAR_BACC = 3'h2,
        FAR_CALL = 3'h3,
        FAR_CALA = 3'h4,
        FAR_RET = 3'h5,
        FAR_RETE = 3'h6
    } pmmp_far_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pmmp_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [19:0] accum;
        logic [15:0] wdata;
    } pmmp_xfer_s;

    typedef struct packed {
        pmmp_far_e op;
        logic delayed;
        logic [19:0] target;
    } pmmp_far_s;

    typedef struct packed {
        logic valid;
        logic [4:0] num;
    } pmmp_vec_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic prog;
        logic [19:0] addr;
        logic [15:0] wdata;
    } pmmp_ext_s;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } pmmp_rsp_s;

endpackage

// [sim/pmmp_ext_mem_model.sv]
`timescale 1ns/1ps
module pmmp_ext_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pacing: slow adds wait cycles
    input wire logic slow,
    // external bus
    input pmmp_pkg::pmmp_ext_s extReq,
    output pmmp_pkg::pmmp_rsp_s extRsp
);
    logic [15:0] mem [bit [20:0]];
    logic pend;
    logic [20:0] key;
    int cnt;

    function automatic logic [15:0] pat(input logic [20:0] k);
        return 16'hC3A5 ^ k[15:0] ^ {11'h000, k[20:16]};
    endfunction

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            cnt <= 0;
            extRsp <= '0;
        end else begin
            extRsp.valid <= 1'b0;
            // idle bus keeps moving so stale data never passes
            extRsp.rdata <= ~extRsp.rdata;
            if (extReq.valid === 1'b1 && extReq.write === 1'b1) begin
                mem[{extReq.prog, extReq.addr}] = extReq.wdata;
            end else if (extReq.valid === 1'b1) begin
                pend <= 1'b1;
                key <= {extReq.prog, extReq.addr};
                cnt <= slow ? 5 : 0;
            end else if (pend && cnt == 0) begin
                pend <= 1'b0;
                extRsp.valid <= 1'b1;
                extRsp.rdata <= mem.exists(key) ? mem[key] : pat(key);
            end else if (pend) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] BOOT_WORD = 16'hA5C3;
    logic clk_sys;
    logic rst;
    logic microModeSelectPin;
    pmmp_pkg::pmmp_req_s progReq;
    pmmp_pkg::pmmp_xfer_s xferReq;
    pmmp_pkg::pmmp_req_s dataReq;
    pmmp_pkg::pmmp_rsp_s progRsp;
    pmmp_pkg::pmmp_rsp_s dataRsp;
    pmmp_pkg::pmmp_far_s farOp;
    logic delaySlotsDone;
    pmmp_pkg::pmmp_vec_s vecTake;
    logic pcLoadValid;
    logic [19:0] pcLoadAddr;
    logic [3:0] programPage;
    pmmp_pkg::pmmp_ext_s extReq;
    pmmp_pkg::pmmp_rsp_s extRsp;
    pmmp_pkg::pmmp_ext_s lastExt;
    logic extSlow;
    int errTotal;
    int checksDone;
    int seed;
    logic [15:0] ramMdl [int];

    pmmp_map #(.BOOT_BRANCH_WORD(BOOT_WORD), .ROM_FILL_WORD(16'h0000)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .microModeSelectPin(microModeSelectPin),
        .progReq(progReq), .xferReq(xferReq), .dataReq(dataReq),
        .progRsp(progRsp), .dataRsp(dataRsp), .farOp(farOp),
        .delaySlotsDone(delaySlotsDone), .vecTake(vecTake),
        .pcLoadValid(pcLoadValid), .pcLoadAddr(pcLoadAddr),
        .programPage(programPage), .extReq(extReq), .extRsp(extRsp));
    pmmp_ext_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .slow(extSlow),
        .extReq(extReq), .extRsp(extRsp));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (extReq.valid === 1'b1) begin
            lastExt <= extReq;
        end
    end

    function automatic logic [15:0] extPat(input logic [20:0] k);
        return 16'hC3A5 ^ k[15:0] ^ {11'h000, k[20:16]};
    endfunction

    task automatic chk(input logic [19:0] seen, exp, input string msg);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t %0s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic doReset();
        int n;
        rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (n < 10 && pcLoadValid !== 1'b1);
        chk(pcLoadAddr, 20'h0FF80, "reset vector");
        chk(programPage, 4'h0, "page at reset");
    endtask

    // kind 0 program, 1 data, 2 accumulator transfer
    task automatic acc(input int kind, input logic wr, input logic [19:0] a,
            input logic [15:0] wd, output logic [15:0] rd);
        int n;
        lastExt = '0;
        @(posedge clk_sys);
        extSlow <= $random(seed);
        if (kind == 0) progReq <= '{1'b1, wr, a[15:0], wd};
        else if (kind == 1) dataReq <= '{1'b1, wr, a[15:0], wd};
        else xferReq <= '{1'b1, wr, a, wd};
        @(posedge clk_sys);
        progReq.valid <= 1'b0;
        dataReq.valid <= 1'b0;
        xferReq.valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            rd = (kind == 1) ? dataRsp.rdata : progRsp.rdata;
        end while (!wr && n < 20 &&
            ((kind == 1) ? dataRsp.valid : progRsp.valid) !== 1'b1);
        if (wr) @(negedge clk_sys);
    endtask

    task automatic far(input int op, input logic dl, input logic [19:0] t);
        logic [3:0] pg;
        pg = programPage;
        @(posedge clk_sys);
        farOp <= '{pmmp_pkg::pmmp_far_e'(op), dl, t};
        @(posedge clk_sys);
        farOp.op <= pmmp_pkg::FAR_NONE;
        if (dl) begin
            @(negedge clk_sys);
            chk(programPage, pg, "page held in slots");
            chk(pcLoadValid, 1'b0, "no early load");
            @(posedge clk_sys);
            delaySlotsDone <= 1'b1;
            @(posedge clk_sys);
            delaySlotsDone <= 1'b0;
        end
        @(negedge clk_sys);
        chk(pcLoadValid, 1'b1, "far load");
        chk(pcLoadAddr, t, "far target");
        chk(programPage, t[19:16], "far page");
    endtask

    task automatic vec(input logic [4:0] n, input logic [8:0] ptr);
        logic [3:0] pg;
        pg = programPage;
        @(posedge clk_sys);
        vecTake <= '{1'b1, n};
        @(posedge clk_sys);
        vecTake.valid <= 1'b0;
        @(negedge clk_sys);
        chk(pcLoadValid, 1'b1, "vector load");
        chk(pcLoadAddr, {pg, ptr, n, 2'b00}, "vector slot");
        chk(programPage, pg, "page kept");
    endtask

    initial begin
        logic [15:0] rd;
        logic [19:0] a;
        logic [15:0] w;
        logic [8:0] ptr;
        logic [3:0] pg;
        seed = 87322;
        rst = 1'b1;
        microModeSelectPin = 1'b0;
        progReq = '0;
        xferReq = '0;
        dataReq = '0;
        farOp = '0;
        delaySlotsDone = 1'b0;
        vecTake = '0;
        extSlow = 1'b0;
        lastExt = '0;
        errTotal = 0;
        checksDone = 0;
        doReset();
        acc(1, 0, 20'h0001D, 16'h0000, rd);
        chk(rd, 16'hFF80, "mode status reset");
        acc(1, 0, 20'h0001E, 16'h0000, rd);
        chk(rd, 16'h0000, "page reg reset");
        $display("test reset done");
        acc(0, 0, 20'h0FF80, 16'h0000, rd);
        chk(rd, BOOT_WORD, "boot branch");
        acc(0, 0, 20'h0FF81, 16'h0000, rd);
        chk(rd, 16'hF800, "boot target");
        acc(0, 1, 20'h0F000, 16'h1234, rd);
        chk(lastExt.valid, 1'b0, "rom write kept inside");
        // reads only: no code image lands in the test words
        for (int i = 0; i < 12; i++) begin
            a = {8'h0F, 12'($random(seed)) & 12'hF7F};
            acc(0, 0, a, 16'h0000, rd);
            chk(rd, 16'h0000, "rom word");
            chk(lastExt.valid, 1'b0, "rom not external");
        end
        $display("test rom done");
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            acc(1, 1, 20'h0001E, w, rd);
            chk(programPage, w[3:0], "page level");
            acc(1, 0, 20'h0001E, 16'h0000, rd);
            chk(rd, {12'h000, w[3:0]}, "page readback");
        end
        $display("test page register done");
        for (int i = 0; i < 40; i++) begin
            a = (i == 0) ? 20'h00060 : (i == 1) ? 20'h01FFF :
                (i == 2) ? 20'h02000 : (i == 3) ? 20'h03FFF :
                20'h00060 + 20'($unsigned($random(seed)) % 32'h3FA0);
            w = $random(seed);
            ramMdl[a] = w;
            acc(1, 1, a, w, rd);
        end
        foreach (ramMdl[k]) begin
            acc(1, 0, k, 16'h0000, rd);
            chk(rd, ramMdl[k], "ram data");
        end
        $display("test data ram done");
        for (int i = 0; i < 8; i++) begin
            a = {4'h0, 16'($random(seed)) | 16'h4000};
            acc(1, 0, a, 16'h0000, rd);
            chk(lastExt.addr, a, "data external addr");
            chk(lastExt.prog, 1'b0, "data space");
            chk(rd, extPat({1'b0, a}), "data external read");
            pg = 4'h1 + 4'($unsigned($random(seed)) % 15);
            acc(1, 1, 20'h0001E, {12'h000, pg}, rd);
            a = {pg, (i[0] ? 16'hF000 : 16'h0000) | (16'($random(seed)) & 16'h3FFF)};
            acc(0, 0, a, 16'h0000, rd);
            chk(lastExt.addr, a, "program external addr");
            chk(lastExt.prog, 1'b1, "program space");
            chk(rd, extPat({1'b1, a}), "program external read");
        end
        $display("test external done");
        ptr = $random(seed);
        acc(1, 1, 20'h0001D, {ptr, 7'h20}, rd);
        acc(1, 0, 20'h0001D, 16'h0000, rd);
        chk(rd, {ptr, 7'h20}, "mode status write");
        foreach (ramMdl[k]) begin
            pg = $random(seed);
            acc(1, 1, 20'h0001E, {12'h000, pg}, rd);
            acc(0, 0, {pg, k[15:0]}, 16'h0000, rd);
            chk(rd, ramMdl[k], "overlay ram");
            chk(lastExt.valid, 1'b0, "overlay on chip");
        end
        for (int i = 0; i < 6; i++) begin
            vec(5'($random(seed)), ptr);
        end
        $display("test overlay and vectors done");
        for (int op = 1; op <= 6; op++) begin
            far(op, 1'b0, 20'($random(seed)));
            far(op, 1'b1, 20'($random(seed)));
        end
        $display("test far ops done");
        for (int i = 0; i < 6; i++) begin
            pg = programPage;
            a = {4'($random(seed)), 2'b01, 14'($random(seed))};
            w = $random(seed);
            acc(2, 1, a, w, rd);
            chk(lastExt.addr, a, "transfer write addr");
            acc(2, 0, a, 16'h0000, rd);
            chk(rd, w, "transfer read");
            chk(programPage, pg, "page after transfer");
        end
        $display("test transfers done");
        // strap high this time: rom leaves the map, mode bit reads set
        @(posedge clk_sys);
        microModeSelectPin <= 1'b1;
        doReset();
        acc(1, 0, 20'h0001D, 16'h0000, rd);
        chk(rd, 16'hFFC0, "pointer back to ones");
        acc(0, 0, 20'h0FF80, 16'h0000, rd);
        chk(lastExt.valid, 1'b1, "strap high rom off");
        chk(rd, extPat({1'b1, 20'h0FF80}), "strap high read");
        vec(5'h03, 9'h1FF);
        $display("test second reset done");
        endSim();
    end

    initial begin
        repeat (50000) @(posedge clk_sys);
        $display("watchdog expired");
        errTotal++;
        endSim();
    end
endmodule
